//--- src/drive_fieldbus_command_status_regs.sv
// command and monitoring holding-register bank of a motor drive
//
// Overview of operation
// - control word bit 3 set issues a coast stop, motor freewheels
// - register 2 holds speed setpoint in 0.1 Hz, read back as written
// - register 3 holds torque setpoint in 0.1 percent, read back
// - register 4 ramp time applies only while ramp control select is 1
// - ramp time accepts 0 to 60000 in 0.01 s steps
// - status bit 0 is running, bit 1 is tripped
// - status bit 3 is inhibit, bit 4 is maintenance time reached
// - status bit 5 is standby sleep, bit 7 is low or high load
// - status bits 2 and 6 carry no function and read zero
// - register 6 holds status low byte and, while tripped, fault number high byte (zero otherwise)
// - register 7 reports output frequency in 0.1 Hz
// - register 8 reports output current in 0.1 A
// - register 9 reports output torque in 0.1 percent
// - register 10 reports output power in 0.01 kW
// - control word bit 2 requests reset of all faults and trips
// - bit 0 enables run, bit 1 requests fast stop on second ramp
// - run, stops and speed only act with source select 4 and no option module; fault reset and torque always pass
`timescale 1ns/10ps
`default_nettype none
module drive_fieldbus_command_status_regs #(
   parameter int DW = 16
) (
   input wire logic clk_sys,                // system clock
   input wire logic sys_rst,                // async reset, active high
   // register access from the protocol engine
   input wire logic reg_wr,                 // write strobe, one cycle
   input wire logic reg_rd,                 // read strobe, one cycle
   input wire logic [15:0] reg_addr,        // register number
   input wire logic [DW-1:0] reg_wdata,     // write data
   output logic [DW-1:0] reg_rdata,         // read data
   output logic reg_rvalid,                 // read data valid pulse
   output logic reg_ack,                    // access accepted pulse
   output logic reg_err,                    // access refused pulse
   // configuration
   input wire logic [3:0] command_source_select,      // source choice
   input wire logic [3:0] fieldbus_ramp_control_select, // ramp choice
   input wire logic option_module_present,  // fieldbus option fitted
   // drive state
   input wire logic drive_running,          // enabled and running
   input wire logic drive_tripped,          // tripped
   input wire logic drive_inhibit,          // inhibited
   input wire logic maint_reached,          // maintenance time reached
   input wire logic standby_active,         // sleep mode
   input wire logic load_fault,             // low or high load seen
   input wire logic [7:0] fault_number,     // active fault code
   input wire logic [DW-1:0] meas_freq,     // output freq, 0.1 Hz
   input wire logic [DW-1:0] meas_current,  // output current, 0.1 A
   input wire logic [DW-1:0] meas_torque,   // output torque, 0.1 %
   input wire logic [DW-1:0] meas_power,    // output power, 0.01 kW
   // commands to motor control
   output logic cmd_run,                    // run enable
   output logic cmd_fast_stop,              // fast stop request
   output logic cmd_fault_reset,            // fault reset request
   output logic cmd_coast_stop,             // coast stop request
   output logic [DW-1:0] cmd_speed,         // speed setpoint
   output logic [DW-1:0] cmd_torque,        // torque setpoint
   output logic cmd_ramp_valid,             // ramp time applies
   output logic [DW-1:0] cmd_ramp_time      // accel and decel time
);
   // writable registers
   logic [DW-1:0] ctrl_reg, ctrl_next;
   logic [DW-1:0] speed_reg, speed_next;
   logic [DW-1:0] torque_reg, torque_next;
   logic [DW-1:0] ramp_reg, ramp_next;
   // command outputs
   logic run_reg, run_next;
   logic fast_reg, fast_next;
   logic frst_reg, frst_next;
   logic coast_reg, coast_next;
   logic [DW-1:0] spd_out_reg, spd_out_next;
   logic [DW-1:0] trq_out_reg, trq_out_next;
   logic rampv_reg, rampv_next;
   logic [DW-1:0] ramp_out_reg, ramp_out_next;
   // access sequencer
   fieldbus_regs_pkg::access_state_t state_reg, state_next;
   logic [DW-1:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic ack_reg, ack_next;
   logic err_reg, err_next;
   // snapshot store
   logic mem_wr;
   logic [3:0] mem_waddr;
   logic [DW-1:0] mem_wdata;
   logic [3:0] mem_raddr_reg, mem_raddr_next;
   logic [DW-1:0] mem_rdata;
   logic [3:0] snap_idx_reg, snap_idx_next;
   // helpers
   logic [7:0] status_byte;
   logic fieldbus_owner;
   logic addr_small;
   logic [3:0] addr_idx;
   logic addr_rw, addr_ro;

   assign addr_small = (reg_addr[15:4] == 12'h000);
   assign addr_idx = reg_addr[3:0];
   assign addr_rw = addr_small &&
      (reg_addr == fieldbus_regs_pkg::ADDR_CONTROL_WORD ||
       reg_addr == fieldbus_regs_pkg::ADDR_SPEED ||
       reg_addr == fieldbus_regs_pkg::ADDR_TORQUE ||
       reg_addr == fieldbus_regs_pkg::ADDR_RAMP);
   assign addr_ro = addr_small &&
      reg_addr >= fieldbus_regs_pkg::ADDR_FAULT_STATUS &&
      reg_addr <= fieldbus_regs_pkg::ADDR_OUT_POWER;

   // packed status byte, unused bits zero
   always_comb begin
      status_byte = 8'h00;
      status_byte[fieldbus_regs_pkg::ST_RUNNING_BIT] = drive_running;
      status_byte[fieldbus_regs_pkg::ST_TRIPPED_BIT] = drive_tripped;
      status_byte[fieldbus_regs_pkg::ST_INHIBIT_BIT] = drive_inhibit;
      status_byte[fieldbus_regs_pkg::ST_MAINT_BIT] = maint_reached;
      status_byte[fieldbus_regs_pkg::ST_STANDBY_BIT] = standby_active;
      status_byte[fieldbus_regs_pkg::ST_LOAD_BIT] = load_fault;
   end

   assign fieldbus_owner = (command_source_select ==
      fieldbus_regs_pkg::SOURCE_FIELDBUS) && !option_module_present;

   // store is refreshed round-robin from the live measurements;
   // setpoint registers take their turn in the same rotation, so reads echo them after a lag
   always_comb begin
      snap_idx_next = snap_idx_reg;
      mem_wr = 1'b1;
      mem_waddr = snap_idx_reg;
      mem_wdata = '0;
      case (snap_idx_reg)
         fieldbus_regs_pkg::ADDR_CONTROL_WORD[3:0]: mem_wdata = ctrl_reg;
         fieldbus_regs_pkg::ADDR_SPEED[3:0]: mem_wdata = speed_reg;
         fieldbus_regs_pkg::ADDR_TORQUE[3:0]: mem_wdata = torque_reg;
         fieldbus_regs_pkg::ADDR_RAMP[3:0]: mem_wdata = ramp_reg;
         fieldbus_regs_pkg::ADDR_FAULT_STATUS[3:0]: begin
            mem_wdata = {(drive_tripped ? fault_number : 8'h00),
               status_byte};
         end
         fieldbus_regs_pkg::ADDR_OUT_FREQ[3:0]: mem_wdata = meas_freq;
         fieldbus_regs_pkg::ADDR_OUT_CURRENT[3:0]: begin
            mem_wdata = meas_current;
         end
         fieldbus_regs_pkg::ADDR_OUT_TORQUE[3:0]: begin
            mem_wdata = meas_torque;
         end
         fieldbus_regs_pkg::ADDR_OUT_POWER[3:0]: begin
            mem_wdata = meas_power;
         end
         default: mem_wr = 1'b0;
      endcase
      if (snap_idx_reg == fieldbus_regs_pkg::STORE_LAST) begin
         snap_idx_next = fieldbus_regs_pkg::STORE_FIRST;
      end else begin
         snap_idx_next = 4'(snap_idx_reg + 4'h1);
      end
   end

   // register writes and access sequencing
   always_comb begin
      ctrl_next = ctrl_reg;
      speed_next = speed_reg;
      torque_next = torque_reg;
      ramp_next = ramp_reg;
      state_next = state_reg;
      rdata_next = rdata_reg;
      rvalid_next = 1'b0;
      ack_next = 1'b0;
      err_next = 1'b0;
      mem_raddr_next = mem_raddr_reg;
      case (state_reg)
         fieldbus_regs_pkg::ST_IDLE: begin
            if (reg_wr) begin
               if (addr_rw) begin
                  ack_next = 1'b1;
                  case (reg_addr)
                     fieldbus_regs_pkg::ADDR_CONTROL_WORD: begin
                        ctrl_next = reg_wdata;
                     end
                     fieldbus_regs_pkg::ADDR_SPEED: begin
                        speed_next = reg_wdata;
                     end
                     fieldbus_regs_pkg::ADDR_TORQUE: begin
                        torque_next = reg_wdata;
                     end
                     default: begin
                        if (reg_wdata <= fieldbus_regs_pkg::RAMP_MAX) begin
                           ramp_next = reg_wdata;
                        end else begin
                           ack_next = 1'b0;
                           err_next = 1'b1;
                        end
                     end
                  endcase
               end else begin
                  err_next = 1'b1;
               end
            end else if (reg_rd) begin
               if (addr_rw || addr_ro) begin
                  ack_next = 1'b1;
                  mem_raddr_next = addr_idx;
                  state_next = fieldbus_regs_pkg::ST_READ;
               end else begin
                  err_next = 1'b1;
               end
            end
         end
         fieldbus_regs_pkg::ST_READ: begin
            state_next = fieldbus_regs_pkg::ST_DONE;
         end
         fieldbus_regs_pkg::ST_DONE: begin
            rdata_next = mem_rdata;
            rvalid_next = 1'b1;
            state_next = fieldbus_regs_pkg::ST_IDLE;
         end
         default: state_next = fieldbus_regs_pkg::ST_IDLE;
      endcase
   end

   // commands to the motor control
   always_comb begin
      run_next = 1'b0;
      fast_next = 1'b0;
      coast_next = 1'b0;
      spd_out_next = '0;
      trq_out_next = torque_reg;
      if (fieldbus_owner) begin
         run_next = ctrl_reg[fieldbus_regs_pkg::CTL_RUN_BIT];
         fast_next = ctrl_reg[fieldbus_regs_pkg::CTL_FAST_STOP_BIT];
         coast_next = ctrl_reg[fieldbus_regs_pkg::CTL_COAST_BIT];
         spd_out_next = speed_reg;
      end
      frst_next = ctrl_reg[fieldbus_regs_pkg::CTL_RESET_BIT];
      rampv_next = (fieldbus_ramp_control_select ==
         fieldbus_regs_pkg::RAMP_CTRL_FIELDBUS);
      ramp_out_next = rampv_next ? ramp_reg : '0;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= fieldbus_regs_pkg::RESET_CONTROL;
         speed_reg <= fieldbus_regs_pkg::RESET_SPEED;
         torque_reg <= fieldbus_regs_pkg::RESET_TORQUE;
         ramp_reg <= fieldbus_regs_pkg::RESET_RAMP;
         state_reg <= fieldbus_regs_pkg::ST_IDLE;
         rdata_reg <= '0;
         rvalid_reg <= 1'b0;
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         mem_raddr_reg <= 4'h0;
         snap_idx_reg <= fieldbus_regs_pkg::STORE_FIRST;
         run_reg <= 1'b0;
         fast_reg <= 1'b0;
         frst_reg <= 1'b0;
         coast_reg <= 1'b0;
         spd_out_reg <= '0;
         trq_out_reg <= '0;
         rampv_reg <= 1'b0;
         ramp_out_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         speed_reg <= speed_next;
         torque_reg <= torque_next;
         ramp_reg <= ramp_next;
         state_reg <= state_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         ack_reg <= ack_next;
         err_reg <= err_next;
         mem_raddr_reg <= mem_raddr_next;
         snap_idx_reg <= snap_idx_next;
         run_reg <= run_next;
         fast_reg <= fast_next;
         frst_reg <= frst_next;
         coast_reg <= coast_next;
         spd_out_reg <= spd_out_next;
         trq_out_reg <= trq_out_next;
         rampv_reg <= rampv_next;
         ramp_out_reg <= ramp_out_next;
      end
   end

   reg_store_mem #(
      .WIDTH(DW),
      .DEPTH(16),
      .AW(4)
   ) reg_store_mem_inst (
      .clk_sys(clk_sys),
      .wr_en(mem_wr),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(mem_raddr_reg),
      .rd_data(mem_rdata)
   );

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;
   assign reg_ack = ack_reg;
   assign reg_err = err_reg;
   assign cmd_run = run_reg;
   assign cmd_fast_stop = fast_reg;
   assign cmd_fault_reset = frst_reg;
   assign cmd_coast_stop = coast_reg;
   assign cmd_speed = spd_out_reg;
   assign cmd_torque = trq_out_reg;
   assign cmd_ramp_valid = rampv_reg;
   assign cmd_ramp_time = ramp_out_reg;
endmodule // drive_fieldbus_command_status_regs
`default_nettype wire

//--- src/fieldbus_regs_pkg.sv
// constants for the drive fieldbus command and status register bank
`default_nettype none
package fieldbus_regs_pkg;
   // register numbers as addressed by the master
   localparam logic [15:0] ADDR_CONTROL_WORD = 16'h0001;
   localparam logic [15:0] ADDR_SPEED = 16'h0002;
   localparam logic [15:0] ADDR_TORQUE = 16'h0003;
   localparam logic [15:0] ADDR_RAMP = 16'h0004;
   localparam logic [15:0] ADDR_FAULT_STATUS = 16'h0006;
   localparam logic [15:0] ADDR_OUT_FREQ = 16'h0007;
   localparam logic [15:0] ADDR_OUT_CURRENT = 16'h0008;
   localparam logic [15:0] ADDR_OUT_TORQUE = 16'h0009;
   localparam logic [15:0] ADDR_OUT_POWER = 16'h000a;
   // first and last register held in the read-back store
   localparam logic [3:0] STORE_FIRST = 4'h1;
   localparam logic [3:0] STORE_LAST = 4'ha;
   // control word bits
   localparam int CTL_RUN_BIT = 0;
   localparam int CTL_FAST_STOP_BIT = 1;
   localparam int CTL_RESET_BIT = 2;
   localparam int CTL_COAST_BIT = 3;
   // status byte bits
   localparam int ST_RUNNING_BIT = 0;
   localparam int ST_TRIPPED_BIT = 1;
   localparam int ST_INHIBIT_BIT = 3;
   localparam int ST_MAINT_BIT = 4;
   localparam int ST_STANDBY_BIT = 5;
   localparam int ST_LOAD_BIT = 7;
   // reset values
   localparam logic [15:0] RESET_CONTROL = 16'h0000;
   localparam logic [15:0] RESET_SPEED = 16'h0000;
   localparam logic [15:0] RESET_TORQUE = 16'h0000;
   localparam logic [15:0] RESET_RAMP = 16'h0000;
   // ramp time limit, 0.01 s units
   localparam logic [15:0] RAMP_MAX = 16'hea60;
   // selector values that hand control to the fieldbus
   localparam logic [3:0] SOURCE_FIELDBUS = 4'h4;
   localparam logic [3:0] RAMP_CTRL_FIELDBUS = 4'h1;
   // access sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_DONE = 2'b11
   } access_state_t;
endpackage
`default_nettype wire

//--- src/reg_store_mem.sv
// small register store with registered read data
`timescale 1ns/10ps
`default_nettype none
module reg_store_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk_sys,            // system clock
   input wire logic wr_en,              // write strobe
   input wire logic [AW-1:0] wr_addr,   // write index
   input wire logic [WIDTH-1:0] wr_data, // write word
   input wire logic [AW-1:0] rd_addr,   // read index
   output logic [WIDTH-1:0] rd_data     // read word, registered
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // reg_store_mem
`default_nettype wire

//--- tb/bus_master.sv
// register bus master model on the protocol side of the bank
`timescale 1ns/10ps
`default_nettype none
module bus_master (
   input wire logic clk_sys,          // clock
   output logic reg_wr,               // write strobe
   output logic reg_rd,               // read strobe
   output logic [15:0] reg_addr,      // register number
   output logic [15:0] reg_wdata,     // write data
   input wire logic [15:0] reg_rdata, // read data
   input wire logic reg_rvalid,       // read valid
   input wire logic reg_ack,          // accepted
   input wire logic reg_err           // refused
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
   end
   // one-cycle strobe, then a bounded wait; e is x on no answer
   task automatic wr(input logic [15:0] a, input logic [15:0] d,
         output logic e);
      int i;
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_wdata = ~d;
      i = 0;
      while (reg_ack !== 1'b1 && reg_err !== 1'b1 && i < 4) begin
         @(negedge clk_sys);
         i++;
      end
      e = (i < 4) ? reg_err : 1'bx;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] q,
         output logic e);
      int i;
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      i = 0;
      while (reg_rvalid !== 1'b1 && reg_err !== 1'b1 && i < 6) begin
         @(negedge clk_sys);
         i++;
      end
      q = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
      e = (i < 6) ? reg_err : 1'bx;
      @(negedge clk_sys);
   endtask
endmodule // bus_master
`default_nettype wire

//--- tb/fieldbus_regs_props.sv
// assertions on the register bank ports
`timescale 1ns/10ps
`default_nettype none
module fieldbus_regs_props #(
   parameter int DW = 16
) (
   input wire logic clk_sys,                 // clock
   input wire logic sys_rst,                 // reset
   input wire logic reg_wr,                  // write strobe
   input wire logic reg_rd,                  // read strobe
   input wire logic [15:0] reg_addr,         // register number
   input wire logic [DW-1:0] reg_wdata,      // write data
   input wire logic reg_rvalid,              // read valid
   input wire logic reg_ack,                 // accepted
   input wire logic reg_err,                 // refused
   input wire logic [3:0] command_source_select, // source
   input wire logic [3:0] fieldbus_ramp_control_select, // ramp choice
   input wire logic option_module_present,   // option fitted
   input wire logic cmd_fault_reset,         // reset request
   input wire logic cmd_coast_stop,          // coast stop
   input wire logic [DW-1:0] cmd_speed,      // speed
   input wire logic [DW-1:0] cmd_torque,     // torque
   input wire logic cmd_ramp_valid,          // ramp applies
   input wire logic [DW-1:0] cmd_ramp_time   // ramp time
);
   logic owner;
   assign owner = !option_module_present &&
      command_source_select == fieldbus_regs_pkg::SOURCE_FIELDBUS;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_coast_stop_cmd: assert property (
      (reg_wr && reg_addr == 16'h0001) ##1 (reg_ack && owner)
      |=> cmd_coast_stop == $past(reg_wdata[3], 2))
      else $error("coast stop output wrong");
   a_fault_reset_cmd: assert property (
      (reg_wr && reg_addr == 16'h0001) ##1 reg_ack
      |=> cmd_fault_reset == $past(reg_wdata[2], 2))
      else $error("fault reset output wrong");
   a_torque_follows: assert property ((reg_wr && reg_addr == 16'h0003)
      ##1 reg_ack |=> cmd_torque == $past(reg_wdata, 2))
      else $error("torque setpoint wrong");
   a_speed_gated: assert property (!owner [*2] |=> cmd_speed == '0)
      else $error("speed passed without ownership");
   a_ramp_gated: assert property (
      (fieldbus_ramp_control_select != 4'h1) [*2]
      |=> !cmd_ramp_valid && cmd_ramp_time == '0)
      else $error("ramp applied while deselected");
   a_ramp_over_limit: assert property (
      reg_wr && reg_addr == 16'h0004 && reg_wdata > 16'hea60
      |=> reg_err && !reg_ack)
      else $error("ramp above limit accepted");
   a_ro_write_refused: assert property (
      reg_wr && reg_addr >= 16'h0006 && reg_addr <= 16'h000a
      |=> reg_err && !reg_ack)
      else $error("write to read-only accepted");
   a_read_answer: assert property ((reg_rd && !reg_wr) ##1
      (reg_ack && !reg_err) |-> ##2 reg_rvalid)
      else $error("read data not delivered");
endmodule // fieldbus_regs_props
bind drive_fieldbus_command_status_regs fieldbus_regs_props #(.DW(DW))
   fieldbus_regs_props_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .reg_ack(reg_ack),
   .reg_err(reg_err), .command_source_select(command_source_select),
   .fieldbus_ramp_control_select(fieldbus_ramp_control_select),
   .option_module_present(option_module_present),
   .cmd_fault_reset(cmd_fault_reset), .cmd_coast_stop(cmd_coast_stop),
   .cmd_speed(cmd_speed), .cmd_torque(cmd_torque),
   .cmd_ramp_valid(cmd_ramp_valid), .cmd_ramp_time(cmd_ramp_time));
`default_nettype wire

//--- tb/drive_fieldbus_command_status_regs_tb_top.sv
// bench for the drive fieldbus register bank
`timescale 1ns/10ps
`default_nettype none
module drive_fieldbus_command_status_regs_tb_top;
   typedef struct {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] rexp;
      logic werr;
   } row_t;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr, reg_rd, reg_rvalid, reg_ack, reg_err, e;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, q;
   logic [3:0] command_source_select = 4'h4;
   logic [3:0] fieldbus_ramp_control_select = 4'h0;
   logic option_module_present = 1'b0;
   logic [7:0] st_in = 8'h00;
   logic [7:0] fault_number = 8'h2a;
   logic [15:0] meas_freq = 16'h007b;
   logic [15:0] meas_current = 16'h0069;
   logic [15:0] meas_torque = 16'h01da;
   logic [15:0] meas_power = 16'h044c;
   logic [15:0] cmd_speed, cmd_torque, cmd_ramp_time;
   logic cmd_run, cmd_fast_stop, cmd_fault_reset, cmd_coast_stop;
   logic cmd_ramp_valid;
   logic [3:0] cmds;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   row_t rows[9];
   assign cmds = {cmd_coast_stop, cmd_fault_reset, cmd_fast_stop, cmd_run};
   always #5 clk_sys = ~clk_sys;
   bus_master bus_master_inst (.clk_sys(clk_sys), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_ack(reg_ack),
      .reg_err(reg_err));
   drive_fieldbus_command_status_regs drive_fieldbus_command_status_regs_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .reg_ack(reg_ack), .reg_err(reg_err),
      .command_source_select(command_source_select),
      .fieldbus_ramp_control_select(fieldbus_ramp_control_select),
      .option_module_present(option_module_present),
      .drive_running(st_in[0]), .drive_tripped(st_in[1]),
      .drive_inhibit(st_in[3]), .maint_reached(st_in[4]),
      .standby_active(st_in[5]), .load_fault(st_in[7]),
      .fault_number(fault_number), .meas_freq(meas_freq),
      .meas_current(meas_current), .meas_torque(meas_torque),
      .meas_power(meas_power),
      .cmd_run(cmd_run), .cmd_fast_stop(cmd_fast_stop),
      .cmd_fault_reset(cmd_fault_reset), .cmd_coast_stop(cmd_coast_stop),
      .cmd_speed(cmd_speed), .cmd_torque(cmd_torque),
      .cmd_ramp_valid(cmd_ramp_valid), .cmd_ramp_time(cmd_ramp_time));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
         input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got,
            exp);
      end
   endtask
   task automatic wrchk(input logic [15:0] a, d, input logic xe);
      bus_master_inst.wr(a, d, e);
      chk({15'h0, e}, {15'h0, xe}, "write answer");
   endtask
   // waits out the read-back snapshot lag first
   task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
      repeat (14) @(negedge clk_sys);
      bus_master_inst.rd(a, q, e);
      chk({15'h0, e}, 16'h0000, "read answer");
      chk(q, exp, "read data");
   endtask
   task automatic results();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         results();
      end
   end
   initial begin
      rows = '{'{16'h0002, 16'h01f4, 16'h01f4, 1'b0},
         '{16'h0003, 16'h07d0, 16'h07d0, 1'b0},
         '{16'h0004, 16'hea60, 16'hea60, 1'b0},
         '{16'h0004, 16'hea61, 16'hea60, 1'b1},
         '{16'h0007, 16'hffff, 16'h007b, 1'b1},
         '{16'h0008, 16'hffff, 16'h0069, 1'b1},
         '{16'h0009, 16'hffff, 16'h01da, 1'b1},
         '{16'h000a, 16'hffff, 16'h044c, 1'b1},
         '{16'h0001, 16'h000f, 16'h000f, 1'b0}};
      repeat (16) @(negedge clk_sys);
      sys_rst = 1'b0;
      foreach (rows[i]) begin
         wrchk(rows[i].addr, rows[i].wdata, rows[i].werr);
         rdchk(rows[i].addr, rows[i].rexp);
      end
      chk({12'h0, cmds}, 16'h000f, "commands");
      chk(cmd_speed, 16'h01f4, "speed out");
      chk(cmd_torque, 16'h07d0, "torque out");
      option_module_present = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk({12'h0, cmds}, 16'h0004, "option fitted");
      chk(cmd_speed, 16'h0000, "speed gated");
      option_module_present = 1'b0;
      command_source_select = 4'h3;
      repeat (3) @(negedge clk_sys);
      chk({12'h0, cmds}, 16'h0004, "other source");
      command_source_select = 4'h4;
      wrchk(16'h0001, 16'h0008, 1'b0);
      repeat (2) @(negedge clk_sys);
      chk({12'h0, cmds}, 16'h0008, "coast only");
      chk({15'h0, cmd_ramp_valid}, 16'h0000, "ramp off");
      fieldbus_ramp_control_select = 4'h1;
      command_source_select = 4'h2;
      repeat (3) @(negedge clk_sys);
      chk({15'h0, cmd_ramp_valid}, 16'h0001, "ramp on");
      chk(cmd_ramp_time, 16'hea60, "ramp time");
      command_source_select = 4'h4;
      st_in = 8'hff;
      rdchk(16'h0006, 16'h2abb);
      st_in = 8'hb5;
      rdchk(16'h0006, 16'h00b1);
      st_in = 8'h4a;
      rdchk(16'h0006, 16'h2a0a);
      meas_freq = 16'h0258;
      meas_power = 16'h0457;
      rdchk(16'h0007, 16'h0258);
      rdchk(16'h000a, 16'h0457);
      bus_master_inst.rd(16'h0005, q, e);
      chk({15'h0, e}, 16'h0001, "hole read");
      wrchk(16'h000b, 16'h1111, 1'b1);
      sys_rst = 1'b1;
      @(negedge clk_sys);
      chk(cmd_speed, 16'h0000, "speed in reset");
      sys_rst = 1'b0;
      rdchk(16'h0002, 16'h0000);
      results();
   end
endmodule // drive_fieldbus_command_status_regs_tb_top
`default_nettype wire
